// *** design/afha_dev.sv ***
`timescale 1ns/10ps
module afha_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [15:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || DEPTH > 4096) begin : g_bad
      $error("afha_fifo depth out of range");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] rd_q;
  logic [AW-1:0] wr_q;
  logic [15:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != 16'(DEPTH));
  assign out_valid = (cnt_q != 16'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;

  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || (clk_en && flush)) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= 16'h0;
    end else if (clk_en) begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + 16'(push) - 16'(pop);
    end
  end
endmodule

// How it works
// R1: Error codes zero none, one to eight.
// R2: Simultaneous errors record the smallest code.
// R3: Busy retry waits gap times 125 us.
// R4: Zero gap resends busy request at once.
// R5: Zero retry maximum means never retry.
// R6: Retry limit exhausted stops, reports busy timeout.
// R7: Missing split response times out, reports code.
// R8: Pipe receive fill flags at bits 31..26.
// R9: Boundary bit marks first or last quadlet.
// R10: Pipe transmit fill flags at bits 23..19.
// R11: Flush bits reset their FIFO, self clear.
// R12: Status flags writable only when unlocked.
// R13: Host writes first, middle, last ports.
// R14: Full transmit FIFO drops writes; commits send.
// R15: Free-space encoding in status bits 23..19.
// R16: Misplaced first quadlet sets start flag.
// R17: Untransmittable tCode sets code error flag.
// R18: Transmit errors hold sending until flush.
// R19: Accept packet if room and ID matches.
// R20: Received packet sets flag, masked interrupt.
// R21: Empty receive read repeats previous quadlet.
// R22: Byte host reads bytes from offset 00.
// R23: Recorded pipe error raises its interrupt.
// R24: Dropped commit leaves fragment never sent.
module afha_dev #(
  parameter int TICK_CYC = afha_pkg::TICK_CYC,
  parameter int ATF_DEPTH = afha_pkg::ATF_DEPTH,
  parameter int ARF_DEPTH = afha_pkg::ARF_DEPTH,
  parameter int PIPE_DEPTH = afha_pkg::PIPE_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register pins
  afha_if.dev bus,
  // Link transmit
  input wire logic tx_grant,
  output logic tx_valid,
  output logic [31:0] tx_data,
  output logic tx_last,
  // Link receive
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [31:0] rx_data,
  input wire logic rx_last,
  input wire logic [15:0] rx_dest_id,
  input wire logic [15:0] rx_len,
  input wire logic [15:0] node_id,
  // Pipe transaction events
  input wire logic pipe_go,
  input wire logic pipe_ack_busy,
  input wire logic pipe_ack_done,
  input wire logic pipe_split,
  input wire logic pipe_resp_rcvd,
  input wire logic [8:1] pipe_err_in,
  output logic pipe_resend,
  output logic pipe_abort,
  // Pipe FIFO levels
  input wire logic [15:0] pipe_tx_count,
  input wire logic [15:0] pipe_rx_count,
  input wire logic pipe_rx_boundary,
  output logic pipe_tx_flush,
  output logic pipe_rx_flush
);

  generate
    if (TICK_CYC < 1 || ATF_DEPTH < 4 || ARF_DEPTH < 2) begin : g_bad
      $error("afha_dev parameters out of range");
    end
  endgenerate

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  logic wr;
  logic rd;
  logic [31:0] wd;
  logic unlock_q;
  logic [31:0] mask_q;
  logic [31:0] tout_q;
  logic [31:0] pst_ovr_q;
  logic [31:0] ast_ovr_q;
  logic [3:0] err_q;
  logic [31:0] rdata_q;
  logic oe_q;
  logic [31:0] last_rx_q;
  logic rx_pkt_q, perr_q, mispl_q, cerr_q;
  logic ptf_q, prf_q, atf_q, arf_q;

  assign wr = clk_en && !bus.wr_n;
  assign rd = clk_en && !bus.rd_n;
  assign wd = bus.host_data;

  // ----------------------------------------
  // Transmit FIFO and packet tracking
  // ----------------------------------------
  logic tx_in_valid, tx_in_ready, tx_out_valid, tx_out_ready;
  logic [33:0] tx_out;
  logic [15:0] tx_cnt;
  logic port_f, port_m, port_l, stored;
  logic in_pkt_q, hold_q;
  logic [15:0] commit_q, uq_q, skip_q, frag_at_q;
  logic send_ok, skipping, tx_done;

  assign port_f = wr && bus.addr == afha_pkg::OFS_TXF;
  assign port_m = wr && bus.addr == afha_pkg::OFS_TXM;
  assign port_l = wr && bus.addr == afha_pkg::OFS_TXL;
  assign tx_in_valid = port_f || port_m || port_l;
  assign stored = tx_in_valid && tx_in_ready; // R14
  assign skipping = skip_q != 16'h0 && frag_at_q == 16'h0;
  assign send_ok = !hold_q && commit_q != 16'h0 && !skipping; // R18
  assign tx_valid = tx_out_valid && send_ok; // R14
  assign tx_out_ready = skipping || (send_ok && tx_grant);
  assign tx_data = tx_out[31:0];
  assign tx_last = tx_out[32];
  assign tx_done = tx_valid && tx_grant && tx_last;

  afha_fifo #(.WIDTH(34), .DEPTH(ATF_DEPTH)) u_atf (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .flush(atf_q),
    .in_valid(tx_in_valid), .in_ready(tx_in_ready), .in_data({1'b0, port_l, wd}),
    .out_valid(tx_out_valid), .out_ready(tx_out_ready), .out_data(tx_out), .count(tx_cnt)
  );

  always_ff @(posedge clk) begin
    if (!rst_n || (clk_en && atf_q)) begin
      in_pkt_q <= 1'b0;
      commit_q <= 16'h0;
      uq_q <= 16'h0;
      skip_q <= 16'h0;
      frag_at_q <= 16'h0;
    end else if (clk_en) begin
      if (port_f) begin
        in_pkt_q <= 1'b1;
      end else if (port_l) begin
        in_pkt_q <= 1'b0;
      end
      commit_q <= commit_q + 16'(stored && port_l) - 16'(tx_done);
      if (stored && !port_l) begin
        uq_q <= uq_q + 16'h1;
      end else if (port_l) begin
        uq_q <= 16'h0;
      end
      // Refused commit: remember where the fragment sits so it is drained unsent
      if (port_l && !tx_in_ready && uq_q != 16'h0) begin // R24
        skip_q <= skip_q + uq_q - 16'(skipping && tx_out_valid);
        frag_at_q <= (skip_q == 16'h0) ? commit_q - 16'(tx_done) : frag_at_q - 16'(tx_done);
      end else begin
        skip_q <= skip_q - 16'(skipping && tx_out_valid); // R24
        frag_at_q <= frag_at_q - 16'(tx_done && skip_q != 16'h0);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || (clk_en && atf_q)) begin
      hold_q <= 1'b0;
    end else if (clk_en && (((port_m || port_l) && !in_pkt_q)
                 || (port_f && !afha_pkg::TCODE_OK[wd[afha_pkg::TCODE_LSB +: 4]]))) begin
      hold_q <= 1'b1; // R18
    end
  end

  // ----------------------------------------
  // Receive FIFO
  // ----------------------------------------
  logic rx_in_pkt_q, acc_q, acc_now, rx_in_ready, rx_out_valid, rx_pop, rx_push;
  logic [33:0] rx_out;
  logic [15:0] rx_cnt;

  assign acc_now = rx_in_pkt_q ? acc_q
                 : (rx_dest_id == node_id && 16'(ARF_DEPTH) - rx_cnt >= rx_len); // R19
  assign rx_ready = acc_now ? rx_in_ready : 1'b1;
  assign rx_push = rx_valid && acc_now;
  assign rx_pop = rd && bus.addr == afha_pkg::OFS_TXM && rx_out_valid; // R21

  afha_fifo #(.WIDTH(34), .DEPTH(ARF_DEPTH)) u_arf (
    .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .flush(arf_q),
    .in_valid(rx_push), .in_ready(rx_in_ready), .in_data({!rx_in_pkt_q, rx_last, rx_data}),
    .out_valid(rx_out_valid), .out_ready(rx_pop), .out_data(rx_out), .count(rx_cnt)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_in_pkt_q <= 1'b0;
      acc_q <= 1'b0;
    end else if (clk_en && rx_valid && rx_ready) begin
      rx_in_pkt_q <= !rx_last;
      acc_q <= acc_now;
    end
  end

  // ----------------------------------------
  // Pipe retry and split timeout
  // ----------------------------------------
  typedef enum logic [1:0] {P_IDLE, P_ACK, P_GAP, P_RESP} afha_pipe_e;
  afha_pipe_e pst_q;
  logic [$clog2(TICK_CYC+1)-1:0] pre_q;
  logic [15:0] ticks_q;
  logic [3:0] tries_q;
  logic tick, load, busy_to, split_to;
  logic [8:1] err_vec;
  logic [3:0] err_new;
  logic [7:0] gap;
  logic [3:0] rmax;

  assign gap = tout_q[afha_pkg::GAP_LSB +: 8];
  assign rmax = tout_q[afha_pkg::RMAX_LSB +: 4];
  assign tick = pre_q == '0;
  assign busy_to = pst_q == P_ACK && pipe_ack_busy && (rmax == 4'h0 || tries_q == rmax); // R5 R6
  assign split_to = pst_q == P_RESP && !pipe_resp_rcvd && tick && ticks_q == 16'h0; // R7
  assign load = (pst_q == P_ACK) && (pipe_ack_busy || pipe_split);
  assign err_vec = pipe_err_in | {4'h0, busy_to, split_to, 2'b00};
  assign pipe_abort = clk_en && pst_q != P_IDLE && err_vec != 8'h0;
  assign pipe_resend = clk_en && ((load && pipe_ack_busy && !busy_to && gap == 8'h0)
                     || (pst_q == P_GAP && tick && ticks_q == 16'h0)); // R4 R3

  always_comb begin
    err_new = afha_pkg::ERR_NONE; // R1
    for (int i = 8; i >= 1; i--) begin
      if (err_vec[i]) begin
        err_new = 4'(i); // R2
      end
    end
  end

  // Prescaler restarts with each wait so an interval is never a tick short
  always_ff @(posedge clk) begin
    if (!rst_n || (clk_en && load)) begin
      pre_q <= ($clog2(TICK_CYC+1))'(TICK_CYC - 1);
    end else if (clk_en) begin
      pre_q <= tick ? ($clog2(TICK_CYC+1))'(TICK_CYC - 1) : pre_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pst_q <= P_IDLE;
      ticks_q <= 16'h0;
      tries_q <= 4'h0;
    end else if (clk_en) begin
      if (pipe_go) begin
        pst_q <= P_ACK;
        tries_q <= 4'h0;
      end else if (pipe_abort) begin
        pst_q <= P_IDLE;
      end else begin
        unique case (pst_q)
          P_IDLE: ;
          P_ACK: begin
            if (pipe_ack_busy) begin
              tries_q <= tries_q + 4'h1;
              ticks_q <= 16'(gap) - 16'h1;
              pst_q <= (gap == 8'h0) ? P_ACK : P_GAP; // R3 R4
            end else if (pipe_split) begin
              ticks_q <= tout_q[afha_pkg::SPLIT_LSB +: 16] - 16'h1; // R7
              pst_q <= P_RESP;
            end else if (pipe_ack_done) begin
              pst_q <= P_IDLE;
            end
          end
          P_GAP: begin
            if (tick) begin
              ticks_q <= ticks_q - 16'h1;
              pst_q <= (ticks_q == 16'h0) ? P_ACK : P_GAP;
            end
          end
          P_RESP: begin
            if (pipe_resp_rcvd) begin
              pst_q <= P_IDLE;
            end else if (tick) begin
              ticks_q <= ticks_q - 16'h1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || (clk_en && pipe_go)) begin
      err_q <= afha_pkg::ERR_NONE;
    end else if (pipe_abort) begin
      err_q <= err_new; // R2
    end
  end

  // ----------------------------------------
  // Interrupt flags, set wins over clear
  // ----------------------------------------
  logic int_wr;
  assign int_wr = wr && bus.addr == afha_pkg::OFS_INT;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_pkt_q <= 1'b0;
      perr_q <= 1'b0;
      mispl_q <= 1'b0;
      cerr_q <= 1'b0;
    end else if (clk_en) begin
      rx_pkt_q <= (rx_push && rx_ready && rx_last) || (rx_pkt_q && !(int_wr && wd[afha_pkg::B_RX_PKT])); // R20
      perr_q <= pipe_abort || (perr_q && !(int_wr && wd[afha_pkg::B_PIPE_ERR])); // R23
      mispl_q <= ((port_m || port_l) && !in_pkt_q)
               || (mispl_q && !(int_wr && wd[afha_pkg::B_MISPLACED])); // R16
      cerr_q <= (port_f && !afha_pkg::TCODE_OK[wd[afha_pkg::TCODE_LSB +: 4]])
              || (cerr_q && !(int_wr && wd[afha_pkg::B_CODE_ERR])); // R17
    end
  end

  assign bus.irq_n = ~|({rx_pkt_q, perr_q, 2'b00, mispl_q, cerr_q} & mask_q[25:20]); // R20

  // ----------------------------------------
  // Control registers and flushes
  // ----------------------------------------
  logic [31:0] pst_live, ast_live, pst_rd, ast_rd;
  logic [4:0] prf_fl, arf_fl;

  assign prf_fl = afha_pkg::fill_flags(pipe_rx_count, 16'(PIPE_DEPTH));
  assign arf_fl = afha_pkg::fill_flags(rx_cnt, 16'(ARF_DEPTH));
  assign pst_live = {prf_fl[4:3], pipe_rx_count >= 16'h0004, pipe_rx_boundary, prf_fl[1:0], 2'b00, // R8 R9
                     afha_pkg::fill_flags(pipe_tx_count, 16'(PIPE_DEPTH)), 3'b000, ptf_q, 1'b0, prf_q, 13'h0}; // R10
  assign ast_live = {arf_fl[4:3], rx_cnt >= 16'h0004, rx_out_valid && (rx_out[33] || rx_out[32]), arf_fl[1:0],
                     2'b00, afha_pkg::fill_flags(tx_cnt, 16'(ATF_DEPTH)), 3'b000, atf_q, 1'b0, arf_q, 13'h0}; // R15
  assign pst_rd = unlock_q ? {pst_ovr_q[31:16], pst_live[15:0]} : pst_live; // R12
  assign ast_rd = unlock_q ? {ast_ovr_q[31:16], ast_live[15:0]} : ast_live;
  assign pipe_tx_flush = ptf_q;
  assign pipe_rx_flush = prf_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      unlock_q <= 1'b0;
      mask_q <= 32'h0;
      tout_q <= afha_pkg::TOUT_RST;
      pst_ovr_q <= afha_pkg::PSTAT_RST;
      ast_ovr_q <= afha_pkg::PSTAT_RST;
      {ptf_q, prf_q, atf_q, arf_q} <= 4'h0;
    end else if (clk_en) begin
      // Flush strobes self clear after one cycle
      ptf_q <= wr && bus.addr == afha_pkg::OFS_PSTAT && wd[afha_pkg::B_TX_FLUSH]; // R11
      prf_q <= wr && bus.addr == afha_pkg::OFS_PSTAT && wd[afha_pkg::B_RX_FLUSH]; // R11
      atf_q <= wr && bus.addr == afha_pkg::OFS_ASTAT && wd[afha_pkg::B_TX_FLUSH]; // R18
      arf_q <= wr && bus.addr == afha_pkg::OFS_ASTAT && wd[afha_pkg::B_RX_FLUSH];
      if (wr && bus.addr == afha_pkg::OFS_CTRL) begin
        unlock_q <= wd[afha_pkg::B_UNLOCK];
      end
      if (wr && bus.addr == afha_pkg::OFS_MASK) begin
        mask_q <= wd;
      end
      if (wr && bus.addr == afha_pkg::OFS_TOUT) begin
        tout_q <= wd;
      end
      if (wr && unlock_q && bus.addr == afha_pkg::OFS_PSTAT) begin
        pst_ovr_q <= wd; // R12
      end
      if (wr && unlock_q && bus.addr == afha_pkg::OFS_ASTAT) begin
        ast_ovr_q <= wd;
      end
    end
  end

  // ----------------------------------------
  // Read answer, one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h0;
      oe_q <= 1'b0;
      last_rx_q <= 32'h0;
    end else if (clk_en) begin
      oe_q <= rd;
      if (rx_pop) begin
        last_rx_q <= rx_out[31:0];
      end
      if (rd) begin
        unique case (bus.addr)
          afha_pkg::OFS_CTRL: rdata_q <= {31'h0, unlock_q};
          afha_pkg::OFS_INT: rdata_q <= {6'h0, rx_pkt_q, perr_q, 2'b00, mispl_q, cerr_q, 20'h0};
          afha_pkg::OFS_MASK: rdata_q <= mask_q;
          afha_pkg::OFS_ASTAT: rdata_q <= ast_rd;
          afha_pkg::OFS_PERR: rdata_q <= {16'h0, err_q, 12'h0};
          afha_pkg::OFS_TOUT: rdata_q <= tout_q;
          afha_pkg::OFS_PSTAT: rdata_q <= pst_rd;
          afha_pkg::OFS_TXM: rdata_q <= rx_out_valid ? rx_out[31:0] : last_rx_q; // R21
          default: rdata_q <= 32'h0;
        endcase
      end
    end
  end

  assign bus.dev_data = rdata_q;
  assign bus.dev_data_oe = oe_q;

endmodule

// *** design/afha_pkg.sv ***
package afha_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_INT = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_ASTAT = 8'h1c;
  localparam logic [7:0] OFS_PERR = 8'h38;
  localparam logic [7:0] OFS_TOUT = 8'h3c;
  localparam logic [7:0] OFS_PSTAT = 8'h40;
  localparam logic [7:0] OFS_TEST = 8'h44;
  localparam logic [7:0] OFS_TXF = 8'h70;
  localparam logic [7:0] OFS_TXM = 8'h74;
  localparam logic [7:0] OFS_TXL = 8'h7c;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int B_UNLOCK = 0;
  localparam int B_RX_PKT = 25;
  localparam int B_PIPE_ERR = 24;
  localparam int B_MISPLACED = 21;
  localparam int B_CODE_ERR = 20;
  localparam int RXF_LSB = 26;
  localparam int TXF_LSB = 19;
  localparam int B_TX_FLUSH = 15;
  localparam int B_RX_FLUSH = 13;
  localparam int ERR_LSB = 12;
  localparam int GAP_LSB = 20;
  localparam int RMAX_LSB = 16;
  localparam int SPLIT_LSB = 0;
  localparam int TCODE_LSB = 4;

  // ----------------------------------------
  // Reset values and depths
  // ----------------------------------------
  localparam logic [31:0] TOUT_RST = 32'h00000320;
  localparam logic [31:0] PSTAT_RST = 32'h04280000;
  localparam int ATF_DEPTH = 24;
  localparam int ARF_DEPTH = 4;
  localparam int PIPE_DEPTH = 532;
  localparam logic [15:0] TCODE_OK = 16'h4af7;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int TICK_US = 125;
  localparam int CLK_MHZ = 100;
  localparam int TICK_CYC = TICK_US * CLK_MHZ;

  // ----------------------------------------
  // Pipe error codes
  // ----------------------------------------
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_SPLIT_TO = 4'h3;
  localparam logic [3:0] ERR_BUSY_TO = 4'h4;

  // Fill flags: full, one slot left, four free, one stored, empty
  function automatic logic [4:0] fill_flags(input logic [15:0] cnt, input logic [15:0] depth);
    fill_flags = {cnt == depth, depth - cnt == 16'h0001, depth - cnt >= 16'h0004,
                  cnt == 16'h0001, cnt == 16'h0000};
  endfunction

endpackage

// *** design/afha_if.sv ***
`timescale 1ns/10ps
interface afha_if;
  logic [7:0] addr;
  logic [31:0] host_data;
  logic [31:0] dev_data;
  logic dev_data_oe;
  logic wr_n;
  logic rd_n;
  logic irq_n;
  logic [31:0] data;

  // Shared data wire: device drives only during a read answer
  assign data = dev_data_oe ? dev_data : host_data;

  modport dev(input addr, host_data, wr_n, rd_n, output dev_data, dev_data_oe, irq_n);
  modport host(input data, irq_n, output addr, host_data, wr_n, rd_n);
endinterface

// *** design/afha_host.sv ***
`timescale 1ns/10ps
module afha_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register pins
  afha_if.host bus,
  // Register commands
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_addr,
  input wire logic [31:0] cmd_wdata,
  output logic rsp_valid,
  output logic [31:0] rsp_rdata,
  // Packet quadlets to send
  input wire logic pkt_valid,
  output logic pkt_ready,
  input wire logic pkt_first,
  input wire logic pkt_last,
  input wire logic [31:0] pkt_data,
  // Interrupt level
  output logic host_irq
);

  typedef enum logic [2:0] {H_IDLE, H_WR, H_RD, H_RDW, H_POLL, H_POLLW, H_PWR} afha_hst_e;
  afha_hst_e st_q;
  logic [7:0] addr_q;
  logic [31:0] wdata_q;
  logic wr_n_q;
  logic rd_n_q;
  logic [31:0] rdata_q;
  logic rsp_q;

  assign cmd_ready = (st_q == H_IDLE);
  assign pkt_ready = (st_q == H_PWR);
  assign bus.addr = addr_q;
  assign bus.host_data = wdata_q;
  assign bus.wr_n = wr_n_q;
  assign bus.rd_n = rd_n_q;
  assign rsp_valid = rsp_q;
  assign rsp_rdata = rdata_q;
  assign host_irq = ~bus.irq_n;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Whole-word accesses at aligned offsets only, so byte order never arises
  always_ff @(posedge clk) begin // R22
    if (!rst_n) begin
      st_q <= H_IDLE;
      addr_q <= 8'h00;
      wdata_q <= 32'h0;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      rdata_q <= 32'h0;
      rsp_q <= 1'b0;
    end else if (clk_en) begin
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      rsp_q <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          if (cmd_valid) begin
            addr_q <= {cmd_addr[7:2], 2'b00};
            wdata_q <= cmd_wdata;
            wr_n_q <= ~cmd_write;
            rd_n_q <= cmd_write;
            st_q <= cmd_write ? H_WR : H_RD;
          end else if (pkt_valid) begin
            st_q <= H_POLL;
          end
        end
        H_WR: st_q <= H_IDLE;
        H_RD: st_q <= H_RDW;
        H_RDW: begin
          rdata_q <= bus.data;
          rsp_q <= 1'b1;
          st_q <= H_IDLE;
        end
        H_POLL: begin
          addr_q <= afha_pkg::OFS_ASTAT;
          rd_n_q <= 1'b0;
          st_q <= H_POLLW;
        end
        H_POLLW: begin
          if (!rd_n_q) begin
            st_q <= H_POLLW;
          end else if (bus.data[afha_pkg::TXF_LSB + 4]) begin // R15
            st_q <= H_POLL;
          end else begin
            // Port choice commits the packet on the last quadlet, except a one-quadlet packet, which goes to the first port
            addr_q <= pkt_first ? afha_pkg::OFS_TXF : (pkt_last ? afha_pkg::OFS_TXL : afha_pkg::OFS_TXM); // R13
            wdata_q <= pkt_data;
            wr_n_q <= 1'b0;
            st_q <= H_PWR;
          end
        end
        H_PWR: st_q <= H_IDLE;
      endcase
    end
  end

endmodule

// *** tb/afha_properties.sv ***
`timescale 1ns/10ps
module afha_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register pins
  input wire logic [7:0] addr,
  input wire logic [31:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic rd_n,
  input wire logic irq_n,
  input wire logic [31:0] data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Read answers
  // ----------------------------------------
  // Reads of the fill status come at least two cycles after a write, so flush bits are gone
  wire logic rd_ps = !rd_n && addr == afha_pkg::OFS_PSTAT;
  chk_read_answer: assert property (!rd_n |=> dev_data_oe && data == dev_data) else $error("no answer");
  chk_answer_cause: assert property (dev_data_oe |-> !$past(rd_n)) else $error("stray answer");
  chk_answer_pulse: assert property (dev_data_oe |=> !dev_data_oe) else $error("long answer");
  chk_flush_clear: assert property (rd_ps |=> !dev_data[15] && !dev_data[13]) else $error("flush stuck");
  chk_rx_flags: assert property (rd_ps |=> !(dev_data[26] && (dev_data[31] || dev_data[27]))) else $error("rx");
  chk_tx_flags: assert property (rd_ps |=> !(dev_data[23] && (dev_data[19] || dev_data[21]))) else $error("tx");
  chk_err_code: assert property (!rd_n && addr == afha_pkg::OFS_PERR |=> dev_data[15:12] <= 4'h8)
    else $error("bad code");
  chk_irq_idle: assert property ($rose(rst_n) |-> irq_n) else $error("irq after reset");
endmodule

// *** tb/test_async_fifo_host_access.sv ***
`timescale 1ns/10ps
module test_async_fifo_host_access;
  logic clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, cmd_valid = 1'h0, cmd_write = 1'h0, pkt_valid = 1'h0;
  logic pkt_first = 1'h0, pkt_last = 1'h0, tx_grant = 1'h0, rx_valid = 1'h0, rx_last = 1'h0, pipe_go = 1'h0;
  logic pipe_ack_busy = 1'h0, pipe_ack_done = 1'h0, pipe_split = 1'h0, pipe_resp_rcvd = 1'h0;
  logic pipe_rx_boundary = 1'h0, pipe_tx_flush, pipe_rx_flush, cmd_ready, rsp_valid, pkt_ready, host_irq;
  logic tx_valid, tx_last, rx_ready, pipe_resend, pipe_abort;
  logic [7:0] cmd_addr = 8'h0;
  logic [8:1] pipe_err_in = 8'h0;
  logic [31:0] cmd_wdata = 32'h0, pkt_data = 32'h0, rx_data = 32'h0, rsp_rdata, tx_data;
  logic [15:0] rx_dest_id = 16'h0, rx_len = 16'h0, node_id = 16'h5, pipe_tx_count = 16'h0, pipe_rx_count = 16'h0;
  logic [1:0] fl_seen = 2'h0;
  logic [32:0] txq[$];
  int n_fail = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    fl_seen <= fl_seen | {pipe_tx_flush, pipe_rx_flush};
    if (tx_valid && tx_grant) txq.push_back({tx_last, tx_data});
  end
  afha_if afha_if_inst();
  afha_host afha_host_inst (.clk, .rst_n, .clk_en, .bus(afha_if_inst), .cmd_valid, .cmd_ready, .cmd_write,
    .cmd_addr, .cmd_wdata, .rsp_valid, .rsp_rdata, .pkt_valid, .pkt_ready, .pkt_first, .pkt_last, .pkt_data,
    .host_irq);
  // Short tick keeps timer waits to tens of cycles
  afha_dev #(.TICK_CYC(20)) afha_dev_inst (.clk, .rst_n, .clk_en, .bus(afha_if_inst), .tx_grant, .tx_valid,
    .tx_data, .tx_last, .rx_valid, .rx_ready, .rx_data, .rx_last, .rx_dest_id, .rx_len, .node_id, .pipe_go,
    .pipe_ack_busy, .pipe_ack_done, .pipe_split, .pipe_resp_rcvd, .pipe_err_in, .pipe_resend, .pipe_abort,
    .pipe_tx_count, .pipe_rx_count, .pipe_rx_boundary, .pipe_tx_flush, .pipe_rx_flush);
  afha_properties afha_properties_inst (.clk, .rst_n, .addr(afha_if_inst.addr), .dev_data(afha_if_inst.dev_data),
    .dev_data_oe(afha_if_inst.dev_data_oe), .rd_n(afha_if_inst.rd_n), .irq_n(afha_if_inst.irq_n),
    .data(afha_if_inst.data));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'h1;
    repeat (20) if (cmd_ready !== 1'h1) step();
    step();
    cmd_valid = 1'h0;
    step();
    if (!w) repeat (20) if (rsp_valid !== 1'h1) step();
  endtask
  task automatic send(input logic f, input logic l, input logic [31:0] d);
    pkt_first = f;
    pkt_last = l;
    pkt_data = d;
    pkt_valid = 1'h1;
    repeat (40) if (pkt_ready !== 1'h1) step();
    step();
    pkt_valid = 1'h0;
    step();
  endtask
  task automatic go();
    pipe_go = 1'h1;
    step();
    pipe_go = 1'h0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    acc(1'h0, afha_pkg::OFS_TOUT, 32'h0); chk(rsp_rdata, afha_pkg::TOUT_RST);
    acc(1'h0, afha_pkg::OFS_ASTAT, 32'h0); chk(rsp_rdata, afha_pkg::PSTAT_RST);
    acc(1'h0, 8'h48, 32'h0); chk(rsp_rdata, 32'h0);
    pipe_rx_count = 16'h214;
    pipe_tx_count = 16'h214;
    acc(1'h0, afha_pkg::OFS_PSTAT, 32'h0); chk(rsp_rdata, 32'ha0800000);
    pipe_rx_count = 16'h1;
    pipe_tx_count = 16'h213;
    pipe_rx_boundary = 1'h1;
    acc(1'h1, afha_pkg::OFS_PSTAT, 32'hffffa000);
    acc(1'h0, afha_pkg::OFS_PSTAT, 32'h0); chk(rsp_rdata, 32'h18400000);
    chk({31'h0, fl_seen}, 33'h3);
    $display("register test done");
  endtask
  task automatic t_pipe();
    acc(1'h1, afha_pkg::OFS_TOUT, 32'h00010000);
    go();
    pipe_ack_busy = 1'h1;
    #1 chk({32'h0, pipe_resend}, 33'h1);
    step();
    #1 chk({32'h0, pipe_abort}, 33'h1);
    step();
    pipe_ack_busy = 1'h0;
    acc(1'h0, afha_pkg::OFS_PERR, 32'h0); chk(rsp_rdata, 32'h4000);
    acc(1'h0, afha_pkg::OFS_INT, 32'h0); chk(rsp_rdata, 32'h01000000);
    go();
    pipe_err_in = 8'h50;
    step();
    pipe_err_in = 8'h0;
    acc(1'h0, afha_pkg::OFS_PERR, 32'h0); chk(rsp_rdata, 32'h5000);
    $display("pipe test done");
  endtask
  task automatic t_link();
    send(1'h1, 1'h0, 32'h00000010);
    send(1'h0, 1'h1, 32'h12345678);
    repeat (4) step();
    chk({32'h0, tx_valid}, 33'h1);
    tx_grant = 1'h1;
    repeat (8) step();
    chk(txq.pop_front(), 33'h000000010);
    chk(txq.pop_front(), 33'h112345678);
    acc(1'h1, afha_pkg::OFS_MASK, 32'h02000000);
    rx_dest_id = node_id;
    rx_len = 16'h1;
    rx_last = 1'h1;
    rx_data = 32'hcafe0001;
    rx_valid = 1'h1;
    repeat (5) if (rx_ready !== 1'h1) step();
    step();
    rx_valid = 1'h0;
    rx_data = 32'h3501fffe;
    repeat (5) if (host_irq !== 1'h1) step();
    chk({32'h0, host_irq}, 33'h1);
    acc(1'h0, afha_pkg::OFS_TXM, 32'h0); chk(rsp_rdata, 32'hcafe0001);
    acc(1'h0, afha_pkg::OFS_TXM, 32'h0); chk(rsp_rdata, 32'hcafe0001);
    $display("link test done");
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst_n = 1'h1;
    t_regs();
    t_pipe();
    t_link();
    test_done();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    n_fail++;
    test_done();
  end
endmodule
